/* hw/dac_pkg.sv */
/*
 * constants, state encodings and the state record of the transfer
 * controller with abort handling and checksum engine.
 * assumes a single system clock and an asynchronous active-low reset.
 */
`default_nettype none

package dac_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int NUM_CH     = 4;
	localparam int CH_W       = 2;
	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 8;
	localparam int CNT_W      = 16;
	localparam int FIFO_DEPTH = 16;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CRC_CTRL   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CRC_RESULT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CRC_INPUT  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CH_BASE    = 8'h20;
	localparam int                CH_IDX_LSB     = 3;
	localparam int                CH_SEL_BIT     = 2;
	localparam int                CH_REGION_LSB  = 5;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_EN_BIT    = 0;
	localparam int CRCC_BEAT_LSB  = 0;
	localparam int CRCC_POLY_BIT  = 2;
	localparam int CRCC_SRC_BIT   = 3;
	localparam int CRCC_EN_BIT    = 4;
	localparam int CH_EN_BIT      = 0;
	localparam int STAT_BUSY_BIT  = 0;
	localparam int STAT_ACT_LSB   = 4;
	localparam int STAT_ENG_BIT   = 8;
	localparam int STAT_STOP_BIT  = 9;

	// ****************************************************************
	// reset values and polynomials
	// ****************************************************************
	localparam logic [31:0]      CRC_RESULT_RST = 32'h0000_0000;
	localparam logic [31:0]      CRC_INPUT_RST  = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CH_COUNT_RST   = 16'h0000;
	localparam logic [15:0]      POLY16         = 16'h1021;
	localparam logic [31:0]      POLY32         = 32'h04c1_1db7;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		ENG_IDLE = 3'b001,
		ENG_BEAT = 3'b010,
		ENG_WB   = 3'b100
	} dac_eng_e;

	typedef struct packed {
		logic                          ctrl_en;
		logic                          ctrl_stop;
		logic [NUM_CH-1:0]             ch_en;
		logic [NUM_CH-1:0]             ch_abort;
		logic [NUM_CH-1:0][CNT_W-1:0]  remain;
		logic [1:0]                    beat;
		logic                          poly32;
		logic                          crc_src;
		logic                          crc_en;
		logic [31:0]                   chk;
		logic [31:0]                   pend;
		logic [1:0]                    cnt;
		logic                          busy;
		logic [31:0]                   din;
		dac_eng_e                      state;
		logic [CH_W-1:0]               act;
		logic [31:0]                   rdata;
		logic                          out_valid;
		logic [DATA_W-1:0]             out_data;
		logic [CH_W-1:0]               out_ch;
	} dac_top_s;

endpackage

`default_nettype wire

/* hw/dac_top.sv */
/*
 * transfer controller with graceful channel abort and a checksum engine,
 * plus the data fifo in front of it.
 * assumes a one-cycle register port on CLK, a source and a sink with
 * valid/ready handshakes in the same clock domain.
 */
// Functional notes
// - on disable, active channel finishes a popped beat and its write-back; one stalled in ENG_BEAT stops without transferring.
// - other enabled idle channels named by the request stop the next cycle.
// - controller disable aborts all channels; channel disable aborts only that one.
// - channel enable bit clears only when the channel has really stopped, unless disabled in the cycle ENG_IDLE picks it.
// - controller enable bit clears only when the whole controller has stopped.
// - checksum is crc-16 ccitt or crc-32 ieee 802.3, selectable.
// - new checksum ready beat field value plus one cycles (1 to 4) after an input word.
// - checksum resets to zero; a direct write loads the start value.
// - checksum writes take effect only while the checksum engine is disabled.
// - crc-32 and not busy: read gives bit-reversed, complemented checksum.
// - crc-16 or busy: read gives the raw checksum register.
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// data fifo
// ****************************************************************
module dac_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
		logic          ready;
		logic          valid;
	} dac_fifo_s;

	dac_fifo_s     q;
	dac_fifo_s     n;
	logic [W-1:0]  mem [DEPTH];
	logic          push;
	logic          pop;

	assign push      = in_valid && q.ready;
	assign pop       = out_ready && q.valid;
	assign in_ready  = q.ready;
	assign out_valid = q.valid;
	assign out_data  = mem[q.rp];

	always_comb begin
		n = q;
		if (push) begin
			n.wp = q.wp + AW'(1);
		end
		if (pop) begin
			n.rp = q.rp + AW'(1);
		end
		n.cnt   = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		n.ready = n.cnt != (AW+1)'(DEPTH);
		n.valid = n.cnt != '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q       <= '0;
			q.ready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[q.wp] <= in_data;
		end
	end
endmodule

// ****************************************************************
// controller top
// ****************************************************************
module dac_top
	import dac_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [31:0]       WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic [31:0]            RDATA,
	input  wire logic              IN_VALID,
	input  wire logic [DATA_W-1:0] IN_DATA,
	output logic                   IN_READY,
	output logic                   OUT_VALID,
	output logic [DATA_W-1:0]      OUT_DATA,
	output logic [CH_W-1:0]        OUT_CH,
	input  wire logic              OUT_READY
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [2:0] beat_bytes(input logic [1:0] b);
		return (b == 2'h0) ? 3'h1 : ((b == 2'h1) ? 3'h2 : 3'h4);
	endfunction

	function automatic logic [31:0] bit_rev(input logic [31:0] v);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 32; i++) begin
			r[i] = v[31-i];
		end
		return r;
	endfunction

	function automatic logic [31:0] crc_calc(input logic [31:0] c, input logic [31:0] d,
		input logic [2:0] nb, input logic p32);
		logic [31:0] r;
		logic        fb;
		r  = c;
		fb = 1'b0;
		for (int i = 0; i < 32; i++) begin
			if (i < 8 * int'(nb)) begin
				if (p32) begin
					fb = r[31] ^ d[i];
					r  = {r[30:0], 1'b0} ^ (fb ? POLY32 : 32'h0000_0000);
				end else begin
					fb = r[15] ^ d[(i & ~7) + 7 - (i & 7)];
					r  = {16'h0000, r[14:0], 1'b0} ^ (fb ? {16'h0000, POLY16} : 32'h0000_0000);
				end
			end
		end
		return r;
	endfunction

	// ****************************************************************
	// state and fifo
	// ****************************************************************
	dac_top_s          q;
	dac_top_s          n;
	logic              fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	logic              pop;
	logic              feed;
	logic [31:0]       feed_data;
	logic              found;
	logic [CH_W-1:0]   pick;
	logic [CH_W-1:0]   wch;
	logic              ch_region;

	dac_fifo #(
		.W     (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst_n     (RST_N),
		.in_valid  (IN_VALID),
		.in_data   (IN_DATA),
		.in_ready  (IN_READY),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (pop)
	);

	assign wch       = ADDR[CH_IDX_LSB +: CH_W];
	assign ch_region = ADDR[ADDR_W-1:CH_REGION_LSB] == OFS_CH_BASE[ADDR_W-1:CH_REGION_LSB];

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		n         = q;
		pop       = 1'b0;
		feed      = 1'b0;
		feed_data = WDATA;
		found     = 1'b0;
		pick      = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (q.ch_en[i] && !q.ch_abort[i] && q.remain[i] != '0) begin
				found = 1'b1;
				pick  = CH_W'(i);
			end
		end

		if (q.out_valid && OUT_READY) begin
			n.out_valid = 1'b0;
		end

		// checksum latency countdown
		if (q.busy) begin
			if (q.cnt == 2'h0) begin
				n.chk  = q.pend;
				n.busy = 1'b0;
			end else begin
				n.cnt = q.cnt - 2'h1;
			end
		end

		// transfer engine
		unique case (q.state)
			ENG_IDLE: begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (q.ch_en[i] && q.remain[i] == '0) begin
						n.ch_en[i] = 1'b0;
					end
				end
				if (q.ctrl_stop) begin
					n.ctrl_en   = 1'b0;
					n.ctrl_stop = 1'b0;
				end else if (q.ctrl_en && found) begin
					n.act   = pick;
					n.state = ENG_BEAT;
				end
			end
			ENG_BEAT: begin
				if (q.ch_abort[q.act]) begin
					n.ch_en[q.act]    = 1'b0;
					n.ch_abort[q.act] = 1'b0;
					n.state           = ENG_IDLE;
				end else if (fifo_valid && (!q.out_valid || OUT_READY)
					&& !(q.crc_src && q.crc_en && q.busy)) begin
					pop         = 1'b1;
					n.out_valid = 1'b1;
					n.out_data  = fifo_data;
					n.out_ch    = q.act;
					feed        = q.crc_src && q.crc_en;
					feed_data   = fifo_data;
					n.state     = ENG_WB;
				end
			end
			ENG_WB: begin
				n.remain[q.act] = q.remain[q.act] - CNT_W'(1);
				if (q.remain[q.act] == CNT_W'(1) || q.ch_abort[q.act]) begin
					n.ch_en[q.act]    = 1'b0;
					n.ch_abort[q.act] = 1'b0;
				end
				n.state = ENG_IDLE;
			end
		endcase

		// software input word
		if (WR && ADDR == OFS_CRC_INPUT) begin
			n.din = WDATA;
			if (q.crc_en && !q.crc_src && !q.busy) begin
				feed = 1'b1;
			end
		end

		if (feed) begin
			n.pend = crc_calc(q.chk, feed_data, beat_bytes(q.beat), q.poly32);
			n.cnt  = q.beat;
			n.busy = 1'b1;
		end

		// register writes
		if (WR) begin
			if (ADDR == OFS_CTRL) begin
				if (WDATA[CTRL_EN_BIT]) begin
					n.ctrl_en   = 1'b1;
					n.ctrl_stop = 1'b0;
				end else if (q.ctrl_en) begin
					n.ctrl_stop = 1'b1;
					for (int i = 0; i < NUM_CH; i++) begin
						if (q.state != ENG_IDLE && q.act == CH_W'(i)) begin
							n.ch_abort[i] = q.ch_en[i];
						end else begin
							n.ch_en[i] = 1'b0;
						end
					end
				end
			end else if (ADDR == OFS_CRC_CTRL) begin
				n.beat    = WDATA[CRCC_BEAT_LSB +: 2];
				n.poly32  = WDATA[CRCC_POLY_BIT];
				n.crc_src = WDATA[CRCC_SRC_BIT];
				n.crc_en  = WDATA[CRCC_EN_BIT];
				if (!WDATA[CRCC_EN_BIT]) begin
					n.busy = 1'b0;
				end
			end else if (ADDR == OFS_CRC_RESULT) begin
				if (!q.crc_en) begin
					n.chk = WDATA;
				end
			end else if (ch_region && !ADDR[CH_SEL_BIT]) begin
				if (WDATA[CH_EN_BIT]) begin
					n.ch_en[wch] = 1'b1;
				end else if (q.ch_en[wch]) begin
					if (q.state == ENG_BEAT && q.act == wch) begin
						n.ch_abort[wch] = 1'b1;
					end else begin
						n.ch_en[wch] = 1'b0;
					end
				end
			end else if (ch_region && ADDR[CH_SEL_BIT]) begin
				if (!q.ch_en[wch]) begin
					n.remain[wch] = WDATA[CNT_W-1:0];
				end
			end
		end

		// register reads, data valid the cycle after the strobe only
		n.rdata = 32'h0000_0000;
		if (RD) begin
			if (ADDR == OFS_CTRL) begin
				n.rdata[CTRL_EN_BIT] = q.ctrl_en;
			end else if (ADDR == OFS_CRC_CTRL) begin
				n.rdata[CRCC_BEAT_LSB +: 2] = q.beat;
				n.rdata[CRCC_POLY_BIT]      = q.poly32;
				n.rdata[CRCC_SRC_BIT]       = q.crc_src;
				n.rdata[CRCC_EN_BIT]        = q.crc_en;
			end else if (ADDR == OFS_CRC_RESULT) begin
				if (q.poly32 && !q.busy) begin
					n.rdata = ~bit_rev(q.chk);
				end else begin
					n.rdata = q.chk;
				end
			end else if (ADDR == OFS_CRC_INPUT) begin
				n.rdata = q.din;
			end else if (ADDR == OFS_STATUS) begin
				n.rdata[STAT_BUSY_BIT]          = q.busy;
				n.rdata[STAT_ACT_LSB +: CH_W]   = q.act;
				n.rdata[STAT_ENG_BIT]           = q.state != ENG_IDLE;
				n.rdata[STAT_STOP_BIT]          = q.ctrl_stop;
			end else if (ch_region && !ADDR[CH_SEL_BIT]) begin
				n.rdata[CH_EN_BIT] = q.ch_en[wch];
			end else if (ch_region && ADDR[CH_SEL_BIT]) begin
				n.rdata[CNT_W-1:0] = q.remain[wch];
			end
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			q        <= '0;
			q.chk    <= CRC_RESULT_RST;
			q.din    <= CRC_INPUT_RST;
			q.remain <= {NUM_CH{CH_COUNT_RST}};
			q.state  <= ENG_IDLE;
		end else begin
			q <= n;
		end
	end

	assign RDATA     = q.rdata;
	assign OUT_VALID = q.out_valid;
	assign OUT_DATA  = q.out_data;
	assign OUT_CH    = q.out_ch;

endmodule

`default_nettype wire

/* sim/dac_properties.sv */
/*
 * port checker of dac_top, with its bind.
 * assumes the software checksum source; engine-fed checksum runs are not modelled.
 */
`timescale 1ns/1ps
`default_nettype none

module dac_properties
	import dac_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST_N,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [31:0]       WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	input  wire logic [31:0]       RDATA,
	input  wire logic              IN_READY,
	input  wire logic              OUT_VALID,
	input  wire logic [DATA_W-1:0] OUT_DATA,
	input  wire logic [CH_W-1:0]   OUT_CH,
	input  wire logic              OUT_READY
);
	// ****************************************************************
	// shadow of control writes
	// ****************************************************************
	logic [4:0]  cc;
	logic        ctl;
	logic [2:0]  bsy;
	logic [31:0] chk;
	logic        kn;
	logic [31:0] rv;
	wire         bon = bsy != 3'h0;
	wire         go  = WR && ADDR == OFS_CRC_INPUT && cc[4] && !cc[3] && !bon;

	always_comb begin
		for (int i = 0; i < 32; i++)
			rv[i] = chk[31-i];
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			cc <= 5'h0;
			ctl <= 1'h0;
			bsy <= 3'h0;
			chk <= 32'h0;
			kn <= 1'h1;
		end else begin
			if (bon)
				bsy <= bsy - 3'h1;
			if (go)
				bsy <= {1'h0, cc[1:0]} + 3'h1;
			if (WR && ADDR == OFS_CRC_CTRL) begin
				cc <= WDATA[4:0];
				if (!WDATA[CRCC_EN_BIT])
					bsy <= 3'h0;
			end
			if (WR && ADDR == OFS_CTRL)
				ctl <= WDATA[CTRL_EN_BIT];
			if (WR && ADDR == OFS_CRC_RESULT && !cc[4]) begin
				chk <= WDATA;
				kn <= 1'h1;
			end
			if (go || (cc[4] && cc[3]))
				kn <= 1'h0;
		end
	end

	// ****************************************************************
	// properties
	// ****************************************************************
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);

	sequence ch_off;
		WR && ADDR[7:5] == 3'h1 && ADDR[2:0] == 3'h0 && !WDATA[CH_EN_BIT] && !ctl;
	endsequence
	sequence ch_off_rd;
		ch_off ##2 (RD && ADDR == $past(ADDR, 2));
	endsequence
	sequence chk_rd16;
		RD && ADDR == OFS_CRC_RESULT && kn && !cc[2];
	endsequence

	rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
		else $error("read data not zero outside a read");
	unmapped_rd_a: assert property (RD && ADDR == 8'hfc |=> RDATA == 32'h0)
		else $error("unmapped read not zero");
	ready_rst_a: assert property ($rose(RST_N) |-> IN_READY)
		else $error("fifo not ready after reset");
	out_hold_a: assert property (
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_CH))
		else $error("output word dropped while stalled");
	busy_flag_a: assert property (
		RD && ADDR == OFS_STATUS && !cc[3] |=> RDATA[STAT_BUSY_BIT] == $past(bon))
		else $error("checksum busy flag wrong");
	chk_raw_a: assert property (chk_rd16 |=> RDATA == $past(chk))
		else $error("raw checksum read wrong");
	chk_rev_a: assert property (
		RD && ADDR == OFS_CRC_RESULT && kn && cc[2] |=> RDATA == ~$past(rv))
		else $error("reversed checksum read wrong");
	ch_stop_a: assert property (ch_off_rd |=> RDATA[CH_EN_BIT] == 1'h0)
		else $error("idle channel still enabled");
endmodule

bind dac_top dac_properties u_props (
	.CLK      (CLK),
	.RST_N    (RST_N),
	.ADDR     (ADDR),
	.WDATA    (WDATA),
	.WR       (WR),
	.RD       (RD),
	.RDATA    (RDATA),
	.IN_READY (IN_READY),
	.OUT_VALID(OUT_VALID),
	.OUT_DATA (OUT_DATA),
	.OUT_CH   (OUT_CH),
	.OUT_READY(OUT_READY)
);

`default_nettype wire

/* sim/dac_top_test.sv */
/*
 * self-checking bench of dac_top.
 * assumes dac_pkg and the checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module dac_top_test
	import dac_pkg::*;
;
	logic              CLK = 1'h0;
	logic              RST_N = 1'h0;
	logic [ADDR_W-1:0] ADDR = 8'h0;
	logic [31:0]       WDATA = 32'h0;
	logic              WR = 1'h0;
	logic              RD = 1'h0;
	logic              IN_VALID = 1'h0;
	logic [DATA_W-1:0] IN_DATA = 32'h0;
	logic              OUT_READY = 1'h0;
	logic [31:0]       RDATA;
	logic              IN_READY;
	logic              OUT_VALID;
	logic [DATA_W-1:0] OUT_DATA;
	logic [CH_W-1:0]   OUT_CH;
	int                n_errors = 0;
	int                checked = 0;
	logic [31:0]       r;

	dac_top dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA), .IN_READY(IN_READY),
		.OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_CH(OUT_CH), .OUT_READY(OUT_READY));

	initial forever #12.5 CLK = ~CLK;

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic give_verdict;
		$display("mismatches %0d of %0d checks", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic hang;
		n_errors++;
		$display("Error at %0t: wait ran out", $time);
		give_verdict;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'h1;
		@(posedge CLK);
		WR <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'h1;
		@(posedge CLK);
		RD <= 1'h0;
		@(negedge CLK);
		d = RDATA;
	endtask

	task automatic poll(input logic [7:0] a);
		for (int k = 0; k <= 20; k++) begin
			if (k == 20)
				hang;
			rd(a, r);
			if (r[0] === 1'h0)
				break;
		end
	endtask

	task automatic push(input logic [31:0] d);
		@(posedge CLK);
		IN_VALID <= 1'h1;
		IN_DATA <= d;
		for (int k = 0; k <= 40; k++) begin
			if (k == 40)
				hang;
			@(negedge CLK);
			if (IN_READY === 1'h1)
				break;
		end
		@(posedge CLK);
		IN_VALID <= 1'h0;
	endtask

	task automatic pop(input logic [31:0] d, input logic [1:0] c);
		for (int k = 0; k <= 40; k++) begin
			if (k == 40)
				hang;
			@(negedge CLK);
			if (OUT_VALID === 1'h1 && OUT_READY === 1'h1)
				break;
		end
		cmp(OUT_DATA, d);
		cmp(OUT_CH, c);
		@(posedge CLK);
	endtask

	function automatic logic [7:0] ca(input int c, input int k);
		return OFS_CH_BASE + 8'(8 * c + 4 * k);
	endfunction

	function automatic logic [31:0] rev(input logic [31:0] v);
		for (int i = 0; i < 32; i++)
			rev[i] = v[31-i];
	endfunction

	function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d, input int b,
		input logic p);
		for (int i = 0; i < (b > 1 ? 32 : 8 * b + 8); i++)
			if (p)
				c = {c[30:0], 1'h0} ^ ((c[31] ^ d[i]) ? POLY32 : 32'h0);
			else
				c[15:0] = {c[14:0], 1'h0} ^ ((c[15] ^ d[(i & ~7) + 7 - (i & 7)]) ? POLY16 : 16'h0);
		return c;
	endfunction

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		repeat (6) @(posedge CLK);
		RST_N <= 1'h1;
		rd(OFS_CRC_RESULT, r);
		cmp(r, 32'h0);
		rd(8'hfc, r);
		cmp(r, 32'h0);
		wr(ca(3, 0), 32'h1);
		wr(ca(3, 0), 32'h0);
		rd(ca(3, 0), r);
		cmp(r[0], 1'h0);
		for (int b = 0; b < 3; b++) begin
			wr(OFS_CRC_CTRL, 32'h0);
			wr(OFS_CRC_RESULT, 32'hffff);
			wr(OFS_CRC_CTRL, 32'h10 | b);
			wr(OFS_CRC_RESULT, 32'h1234);
			wr(OFS_CRC_INPUT, 32'ha5c3_0f96 + b);
			rd(OFS_STATUS, r);
			cmp(r[0], b > 0);
			rd(OFS_CRC_RESULT, r);
			cmp(r, crc(32'hffff, 32'ha5c3_0f96 + b, b, 1'h0));
		end
		wr(OFS_CRC_CTRL, 32'h0);
		wr(OFS_CRC_RESULT, 32'hffff_ffff);
		wr(OFS_CRC_CTRL, 32'h16);
		rd(OFS_CRC_RESULT, r);
		cmp(r, 32'h0);
		wr(OFS_CRC_INPUT, 32'h3132_3334);
		rd(OFS_CRC_RESULT, r);
		cmp(r, 32'hffff_ffff);
		rd(OFS_CRC_RESULT, r);
		cmp(r, ~rev(crc(32'hffff_ffff, 32'h3132_3334, 2, 1'h1)));
		for (int i = 0; i < 16; i++)
			push(32'h100 + i);
		@(negedge CLK);
		cmp(IN_READY, 1'h0);
		wr(OFS_CTRL, 32'h1);
		wr(ca(0, 1), 32'h10);
		wr(ca(0, 0), 32'h1);
		@(posedge CLK) OUT_READY <= 1'h1;
		for (int i = 0; i < 16; i++)
			pop(32'h100 + i, 2'h0);
		poll(ca(0, 0));
		@(posedge CLK) OUT_READY <= 1'h0;
		for (int i = 0; i < 3; i++)
			push(32'h200 + i);
		wr(ca(1, 1), 32'h4);
		wr(ca(2, 1), 32'h4);
		wr(ca(1, 0), 32'h1);
		wr(ca(2, 0), 32'h1);
		wr(ca(2, 0), 32'h0);
		rd(ca(2, 0), r);
		cmp(r[0], 1'h0);
		// stalled before its next beat began, so the channel stops at once
		wr(ca(1, 0), 32'h0);
		rd(ca(1, 0), r);
		cmp(r[0], 1'h0);
		@(posedge CLK) OUT_READY <= 1'h1;
		pop(32'h200, 2'h1);
		poll(ca(1, 0));
		rd(ca(1, 1), r);
		cmp(r, 32'h3);
		rd(ca(2, 1), r);
		cmp(r, 32'h4);
		@(posedge CLK) OUT_READY <= 1'h0;
		wr(ca(0, 1), 32'h2);
		wr(ca(3, 1), 32'h2);
		wr(ca(0, 0), 32'h1);
		wr(ca(3, 0), 32'h1);
		push(32'h203);
		wr(OFS_CTRL, 32'h0);
		// stop still pending two cycles after the disable
		rd(OFS_CTRL, r);
		cmp(r[0], 1'h1);
		rd(ca(3, 0), r);
		cmp(r[0], 1'h0);
		@(posedge CLK) OUT_READY <= 1'h1;
		pop(32'h201, 2'h0);
		poll(OFS_CTRL);
		rd(ca(0, 0), r);
		cmp(r[0], 1'h0);
		// resume: channel 0 kept one beat in its write-back count
		wr(OFS_CTRL, 32'h1);
		wr(ca(0, 0), 32'h1);
		pop(32'h202, 2'h0);
		wr(ca(3, 0), 32'h1);
		pop(32'h203, 2'h3);
		give_verdict;
	end
endmodule

`default_nettype wire
